// >>> rtl/rsse_pkg.sv
package rsse_pkg;
    // ****************************************
    // operation codes
    // ****************************************
    typedef enum logic [2:0] {
        RSSE_OP_NONE,
        RSSE_OP_ROTATE_LEFT,
        RSSE_OP_ROTATE_RIGHT,
        RSSE_OP_SUB_LITERAL,
        RSSE_OP_SUB_FILE,
        RSSE_OP_SLEEP
    } rsse_op_t;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int RSSE_DATA_W = 8;
    localparam int RSSE_ADDR_W = 7;
    localparam int RSSE_WDT_W = 8;
    localparam int RSSE_PRE_W = 16;
    localparam int RSSE_NIB_MSB = 3;
    localparam int RSSE_MSB = 7;
    localparam logic [7:0] RSSE_W_RST = 8'h00;
    localparam logic [7:0] RSSE_WDT_CLEAR = 8'h00;
    localparam logic [15:0] RSSE_PRE_CLEAR = 16'h0000;
    localparam logic RSSE_DEST_W = 1'b0;
    localparam logic RSSE_DEST_FILE = 1'b1;
    localparam logic RSSE_PD_N_RST = 1'b1;
    localparam logic RSSE_TO_N_RST = 1'b1;
endpackage

// >>> rtl/rsse_exec.sv
`timescale 1ns/10ps
module rsse_exec
    import rsse_pkg::*;
(
    input wire logic clk_sys, // core instruction clock
    input wire logic rst, // synchronous reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire logic op_valid, // instruction present this cycle
    input wire rsse_op_t op_code, // decoded operation
    input wire logic dest_sel, // 0 working register, 1 file register
    input wire logic [6:0] file_addr, // addressed file register
    input wire logic [7:0] file_rdata, // value of addressed file register
    input wire logic [7:0] literal, // 8-bit literal
    input wire logic wake, // wake event leaves sleep
    output logic [7:0] w_value, // working register
    output logic carry_flag, // carry / not borrow
    output logic digit_carry_flag, // digit carry / not borrow
    output logic zero_flag, // zero result
    output logic power_down_flag_n, // active-low power-down status
    output logic time_out_flag_n, // active-low time-out status
    output logic file_we, // one-cycle file write strobe
    output logic [6:0] file_waddr, // file write address
    output logic [7:0] file_wdata, // file write data
    output logic [7:0] watchdog_counter, // watchdog count
    output logic [15:0] watchdog_prescaler, // watchdog prescaler
    output logic osc_halt, // oscillator stopped
    output logic fetch_stall // instruction fetch stopped
);
    // ****************************************
    // state declarations
    // ****************************************
    typedef enum logic {RSSE_RUN, RSSE_ASLEEP} rsse_state_t;
    rsse_state_t state_reg;
    rsse_state_t state_next;
    logic halt_reg;
    logic halt_next;
    logic stall_reg;
    logic stall_next;
    logic [7:0] w_reg;
    logic [7:0] w_next;
    logic c_reg;
    logic c_next;
    logic dc_reg;
    logic dc_next;
    logic z_reg;
    logic z_next;
    logic pd_n_reg;
    logic pd_n_next;
    logic to_n_reg;
    logic to_n_next;
    logic we_reg;
    logic we_next;
    logic [6:0] waddr_reg;
    logic [6:0] waddr_next;
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    logic [7:0] wdt_reg;
    logic [7:0] wdt_next;
    logic [15:0] pre_reg;
    logic [15:0] pre_next;

    // ****************************************
    // decode and datapath nets
    // ****************************************
    logic take;
    logic is_rot_left;
    logic is_rot_right;
    logic is_sub_lit;
    logic is_sub_file;
    logic is_sleep;
    logic is_rotate;
    logic is_sub;
    logic to_file;
    logic to_w;
    logic [7:0] sub_a;
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic [7:0] rot_left_val;
    logic [7:0] rot_right_val;
    logic [7:0] result;
    logic diff_zero;

    // ****************************************
    // instruction decode
    // ****************************************
    // ops offered while asleep are dropped, not queued
    always_comb begin
        take = op_valid && (state_reg == RSSE_RUN);
        is_rot_left = take && (op_code == RSSE_OP_ROTATE_LEFT);
        is_rot_right = take && (op_code == RSSE_OP_ROTATE_RIGHT);
        is_sub_lit = take && (op_code == RSSE_OP_SUB_LITERAL);
        is_sub_file = take && (op_code == RSSE_OP_SUB_FILE);
        is_sleep = take && (op_code == RSSE_OP_SLEEP);
        is_rotate = is_rot_left || is_rot_right;
        is_sub = is_sub_lit || is_sub_file;
        // literal subtract ignores dest and always lands in W
        to_file = (is_rotate || is_sub_file) &&
            (dest_sel == RSSE_DEST_FILE);
        to_w = is_sub_lit ||
            ((is_rotate || is_sub_file) &&
            (dest_sel == RSSE_DEST_W));
    end

    // ****************************************
    // arithmetic
    // ****************************************
    // the ninth bit of diff is the borrow, so carry is its inverse
    always_comb begin
        if (is_sub_lit) begin
            sub_a = literal;
        end else begin
            sub_a = file_rdata;
        end
        diff = {1'b0, sub_a} - {1'b0, w_reg};
        ndiff = {1'b0, sub_a[RSSE_NIB_MSB:0]} -
            {1'b0, w_reg[RSSE_NIB_MSB:0]};
        rot_left_val = {file_rdata[RSSE_MSB-1:0], c_reg};
        rot_right_val = {c_reg, file_rdata[RSSE_MSB:1]};
        diff_zero = (diff[RSSE_MSB:0] == 8'h00);
        if (is_rot_left) begin
            result = rot_left_val;
        end else if (is_rot_right) begin
            result = rot_right_val;
        end else begin
            result = diff[RSSE_MSB:0];
        end
    end

    // ****************************************
    // working register
    // ****************************************
    always_comb begin
        w_next = w_reg;
        if (to_w) begin
            w_next = result;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_reg <= RSSE_W_RST;
        end else if (clk_en) begin
            w_reg <= w_next;
        end
    end

    // ****************************************
    // arithmetic flags
    // ****************************************
    // rotates leave digit carry and zero alone
    always_comb begin
        c_next = c_reg;
        dc_next = dc_reg;
        z_next = z_reg;
        if (is_rot_left) begin
            c_next = file_rdata[RSSE_MSB];
        end else if (is_rot_right) begin
            c_next = file_rdata[0];
        end else if (is_sub) begin
            c_next = ~diff[RSSE_DATA_W];
            dc_next = ~ndiff[RSSE_NIB_MSB+1];
            z_next = diff_zero;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            c_reg <= 1'b0;
            dc_reg <= 1'b0;
            z_reg <= 1'b0;
        end else if (clk_en) begin
            c_reg <= c_next;
            dc_reg <= dc_next;
            z_reg <= z_next;
        end
    end

    // ****************************************
    // file write-back
    // ****************************************
    // address and data hold after the strobe drops
    always_comb begin
        we_next = to_file;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        if (to_file) begin
            waddr_next = file_addr;
            wdata_next = result;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            we_reg <= 1'b0;
            waddr_reg <= 7'h00;
            wdata_reg <= 8'h00;
        end else if (clk_en) begin
            we_reg <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
        end
    end

    // ****************************************
    // sleep control and status
    // ****************************************
    // halt and stall are registered copies of the next state
    always_comb begin
        state_next = state_reg;
        pd_n_next = pd_n_reg;
        to_n_next = to_n_reg;
        wdt_next = wdt_reg;
        pre_next = pre_reg;
        case (state_reg)
            RSSE_RUN: begin
                if (is_sleep) begin
                    wdt_next = RSSE_WDT_CLEAR;
                    pre_next = RSSE_PRE_CLEAR;
                    pd_n_next = 1'b0;
                    to_n_next = 1'b1;
                    state_next = RSSE_ASLEEP;
                end
            end
            RSSE_ASLEEP: begin
                if (wake) begin
                    state_next = RSSE_RUN;
                end
            end
            default: begin
                state_next = RSSE_RUN;
            end
        endcase
        halt_next = (state_next == RSSE_ASLEEP);
        stall_next = (state_next == RSSE_ASLEEP);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= RSSE_RUN;
            halt_reg <= 1'b0;
            stall_reg <= 1'b0;
            pd_n_reg <= RSSE_PD_N_RST;
            to_n_reg <= RSSE_TO_N_RST;
            wdt_reg <= RSSE_WDT_CLEAR;
            pre_reg <= RSSE_PRE_CLEAR;
        end else if (clk_en) begin
            state_reg <= state_next;
            halt_reg <= halt_next;
            stall_reg <= stall_next;
            pd_n_reg <= pd_n_next;
            to_n_reg <= to_n_next;
            wdt_reg <= wdt_next;
            pre_reg <= pre_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output is a flop, never a decode
    assign w_value = w_reg;
    assign carry_flag = c_reg;
    assign digit_carry_flag = dc_reg;
    assign zero_flag = z_reg;
    assign power_down_flag_n = pd_n_reg;
    assign time_out_flag_n = to_n_reg;
    assign file_we = we_reg;
    assign file_waddr = waddr_reg;
    assign file_wdata = wdata_reg;
    assign watchdog_counter = wdt_reg;
    assign watchdog_prescaler = pre_reg;
    assign osc_halt = halt_reg;
    assign fetch_stall = stall_reg;
endmodule

// >>> verification/rsse_file_model.sv
`timescale 1ns/10ps
module rsse_file_model (
    input wire logic clk_sys, // clock
    input wire logic [6:0] file_addr, // read address
    output logic [7:0] file_rdata, // read value
    input wire logic file_we, // write strobe
    input wire logic [6:0] file_waddr, // write address
    input wire logic [7:0] file_wdata // write data
);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 8'h3B);
    always @(posedge clk_sys) if (file_we) mem[file_waddr] <= file_wdata;
    assign file_rdata = mem[file_addr];
endmodule

// >>> verification/rsse_exec_sva.sv
`timescale 1ns/10ps
module rsse_exec_chk
    import rsse_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic clk_en, // enable
    input wire logic op_valid, // op present
    input wire rsse_op_t op_code, // op
    input wire logic dest_sel, // destination
    input wire logic [7:0] file_rdata, // file value
    input wire logic [7:0] literal, // literal
    input wire logic [7:0] w_value, // working reg
    input wire logic carry_flag, // carry
    input wire logic digit_carry_flag, // digit carry
    input wire logic zero_flag, // zero
    input wire logic power_down_flag_n, // power down
    input wire logic time_out_flag_n, // time out
    input wire logic file_we, // write strobe
    input wire logic [7:0] file_wdata, // write data
    input wire logic osc_halt, // halted
    input wire logic fetch_stall // stalled
);
    wire logic take = clk_en && op_valid && !fetch_stall;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    rot_left_a: assert property (
        take && op_code == RSSE_OP_ROTATE_LEFT && !dest_sel |=>
        {carry_flag, w_value} == {$past(file_rdata), $past(carry_flag)})
        else $error("rotate left");
    rot_right_a: assert property (
        take && op_code == RSSE_OP_ROTATE_RIGHT && dest_sel |=>
        file_we &&
        {file_wdata, carry_flag} == {$past(carry_flag), $past(file_rdata)})
        else $error("rotate right");
    rot_flags_a: assert property (
        take &&
        op_code inside {RSSE_OP_ROTATE_LEFT, RSSE_OP_ROTATE_RIGHT} |=>
        $stable(zero_flag) && $stable(digit_carry_flag))
        else $error("rotate touched flags");
    sub_lit_a: assert property (
        take && op_code == RSSE_OP_SUB_LITERAL |=>
        w_value == $past(literal) - $past(w_value) && !file_we &&
        carry_flag == ($past(w_value) <= $past(literal)) &&
        digit_carry_flag ==
        (4'($past(w_value)) <= 4'($past(literal))))
        else $error("subtract literal");
    sub_zero_a: assert property (
        take && op_code == RSSE_OP_SUB_FILE |=>
        zero_flag == ($past(file_rdata) == $past(w_value)) &&
        carry_flag == ($past(w_value) <= $past(file_rdata)))
        else $error("subtract file flags");
    sub_dest_a: assert property (
        take && op_code == RSSE_OP_SUB_FILE && dest_sel |=>
        file_we && $stable(w_value) &&
        file_wdata == $past(file_rdata) - $past(w_value))
        else $error("subtract file dest");
    sleep_entry_a: assert property (
        take && op_code == RSSE_OP_SLEEP |=>
        !power_down_flag_n && time_out_flag_n && osc_halt &&
        fetch_stall && $stable(w_value))
        else $error("sleep entry");
    we_cause_a: assert property (
        file_we |-> $past(take) && $past(dest_sel))
        else $error("stray file write");
endmodule
bind rsse_exec rsse_exec_chk chk (.*);

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import rsse_pkg::*;
    logic clk_sys = 0, rst = 1, clk_en = 1, op_valid = 0, dest_sel = 0;
    logic wake = 0, c = 0, dc = 0, z = 0;
    rsse_op_t op_code = RSSE_OP_NONE;
    logic [6:0] file_addr = 7'h00, file_waddr;
    logic [7:0] file_rdata, literal = 8'h00, w_value, file_wdata, f, r;
    logic [7:0] w = 8'h00, watchdog_counter;
    logic carry_flag, digit_carry_flag, zero_flag, power_down_flag_n;
    logic time_out_flag_n, file_we, osc_halt, fetch_stall;
    logic [15:0] watchdog_prescaler;
    int num_errors = 0, compares = 0;
    rsse_exec uut (.*);
    rsse_file_model fm (.*);
    initial forever #50 clk_sys = ~clk_sys;
    task conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task exec(input rsse_op_t o, input logic d, input logic [6:0] a,
        input logic [7:0] k, input logic t);
        logic wd;
        @(posedge clk_sys);
        op_valid <= 1;
        op_code <= o;
        dest_sel <= d;
        file_addr <= a;
        literal <= k;
        @(negedge clk_sys);
        f = (o == RSSE_OP_SUB_LITERAL) ? k : file_rdata;
        wd = t && d && o inside {RSSE_OP_ROTATE_LEFT, RSSE_OP_ROTATE_RIGHT,
            RSSE_OP_SUB_FILE};
        r = w;
        if (t) begin
            case (o)
                RSSE_OP_ROTATE_LEFT: {c, r} = {f, c};
                RSSE_OP_ROTATE_RIGHT: {r, c} = {c, f};
                RSSE_OP_SUB_LITERAL, RSSE_OP_SUB_FILE: begin
                    c = w <= f;
                    dc = w[3:0] <= f[3:0];
                    r = f - w;
                    z = r == 8'h00;
                end
                default: ;
            endcase
        end
        @(posedge clk_sys);
        op_valid <= 0;
        @(negedge clk_sys);
        if (!wd) w = r;
        chk(file_we, wd);
        if (wd) chk({file_waddr, file_wdata}, {a, r});
        chk(w_value, w);
        chk({carry_flag, digit_carry_flag, zero_flag}, {c, dc, z});
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        chk({power_down_flag_n, time_out_flag_n, osc_halt, file_we, w_value},
            12'hC00);
        rst <= 0;
        for (int i = 0; i < 40; i++) begin
            exec(rsse_op_t'(1 + i % 4), i[2], 7'(i * 5), 8'(i * 29), 1);
        end
        exec(RSSE_OP_SUB_LITERAL, 0, 7'h00, w, 1);
        exec(RSSE_OP_SUB_LITERAL, 0, 7'h00, w - 8'h01, 1);
        @(posedge clk_sys);
        clk_en <= 0;
        exec(RSSE_OP_SUB_FILE, 1, 7'h03, 8'h00, 0);
        @(posedge clk_sys);
        clk_en <= 1;
        exec(RSSE_OP_NONE, 1, 7'h03, 8'h00, 0);
        exec(RSSE_OP_SLEEP, 0, 7'h00, 8'h00, 1);
        chk({power_down_flag_n, time_out_flag_n, osc_halt,
            fetch_stall}, 4'h7);
        chk({watchdog_counter, watchdog_prescaler}, 24'h000000);
        exec(RSSE_OP_SUB_LITERAL, 0, 7'h00, 8'h55, 0);
        @(posedge clk_sys);
        wake <= 1;
        @(posedge clk_sys);
        wake <= 0;
        @(negedge clk_sys);
        chk({power_down_flag_n, osc_halt, fetch_stall}, 3'h0);
        exec(RSSE_OP_SUB_LITERAL, 0, 7'h00, 8'h80, 1);
        conclude();
    end
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule
